//--- core/pulse_addition_pwm_outputs.sv
/*
 * Sixteen-channel 8-bit pulse-addition PWM with pin muxing and AXI4-Lite registers.
 * Assumes an AXI4-Lite master on aclk, pin inputs from outside the clock domain,
 * and an address bus from same-clock logic for pins that may not act as port output.
 */
module pulse_addition_pwm_outputs
    import pwm_pkg::*;
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [ADDR_W-1:0]         awaddr,
    input  wire logic                      awvalid,
    output logic                           awready,
    input  wire logic [31:0]               wdata,
    input  wire logic [3:0]                wstrb,
    input  wire logic                      wvalid,
    output logic                           wready,
    output logic [1:0]                     bresp,
    output logic                           bvalid,
    input  wire logic                      bready,
    input  wire logic [ADDR_W-1:0]         araddr,
    input  wire logic                      arvalid,
    output logic                           arready,
    output logic [31:0]                    rdata,
    output logic [1:0]                     rresp,
    output logic                           rvalid,
    input  wire logic                      rready,
    input  wire logic [NUM_CHANNELS-1:0]   pin_in,
    input  wire logic [NUM_CHANNELS-1:0]   address_bus,
    output logic [NUM_CHANNELS-1:0]        pin_out,
    output logic [NUM_CHANNELS-1:0]        pin_oe
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0]               pin_enable_reg_low_q;
    logic [7:0]               pin_enable_reg_high_q;
    logic [7:0]               clock_select_reg_q;
    pwm_select_type           pwm_select_reg_q;
    logic [7:0]               polarity_reg_low_q;
    logic [7:0]               polarity_reg_high_q;
    logic [7:0]               port1_direction_reg_q;
    logic [7:0]               port2_direction_reg_q;
    logic [7:0]               port1_data_reg_q;
    logic [7:0]               port2_data_reg_q;
    system_control_type       system_control_reg_q;
    logic [7:0]               duty_value_reg_q [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0]  pin_meta_q;
    logic [NUM_CHANNELS-1:0]  pin_sync_q;
    logic [3:0]               prescale_q;
    logic [7:0]               counter_q;
    logic                     aw_held_q;
    logic                     w_held_q;
    logic [ADDR_W-1:0]        aw_addr_q;
    logic [7:0]               w_byte_q;
    logic                     w_lane_q;
    logic [ADDR_W-1:0]        ar_addr_q;

    logic                     do_write;
    logic                     tick;
    logic [NUM_CHANNELS-1:0]  channel_output_enable;
    logic [NUM_CHANNELS-1:0]  polarity_bit;
    logic [NUM_CHANNELS-1:0]  pin_direction;
    logic [NUM_CHANNELS-1:0]  port_data;
    logic [NUM_CHANNELS-1:0]  pwm_wave;
    logic [NUM_CHANNELS-1:0]  pin_out_d;
    logic                     port_allowed;
    logic [31:0]              read_value;
    logic                     read_hit;
    logic                     write_hit;

    assign channel_output_enable = {pin_enable_reg_high_q, pin_enable_reg_low_q};
    assign polarity_bit          = {polarity_reg_high_q, polarity_reg_low_q};
    assign pin_direction         = {port2_direction_reg_q, port1_direction_reg_q};
    assign port_data             = {port2_data_reg_q, port1_data_reg_q};

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign do_write = aw_held_q && w_held_q && !bvalid;

    always_comb
    begin
        write_hit = 1'b1;
        if (aw_addr_q[7:6] != DUTY_BLOCK_SEL)
        begin
            unique case (aw_addr_q)
                PIN_ENABLE_LOW_OFF, PIN_ENABLE_HIGH_OFF, CLOCK_SELECT_OFF, PWM_SELECT_OFF,
                POLARITY_LOW_OFF, POLARITY_HIGH_OFF, PORT1_DIR_OFF, PORT2_DIR_OFF,
                PORT1_DATA_OFF, PORT2_DATA_OFF, SYSTEM_CONTROL_OFF: write_hit = 1'b1;
                default: write_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= '0;
            w_byte_q  <= REG_RESET;
            w_lane_q  <= 1'b0;
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_held_q <= 1'b1;
                w_byte_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
                wready   <= 1'b0;
            end
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= write_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Registers are at most 8 bits wide, so only byte lane 0 carries a write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_enable_reg_low_q  <= REG_RESET;
            pin_enable_reg_high_q <= REG_RESET;
            clock_select_reg_q    <= REG_RESET;
            pwm_select_reg_q      <= '0;
            polarity_reg_low_q    <= REG_RESET;
            polarity_reg_high_q   <= REG_RESET;
            port1_direction_reg_q <= REG_RESET;
            port2_direction_reg_q <= REG_RESET;
            port1_data_reg_q      <= REG_RESET;
            port2_data_reg_q      <= REG_RESET;
            system_control_reg_q  <= '0;
            for (int i = 0; i < NUM_CHANNELS; i++)
            begin
                duty_value_reg_q[i] <= REG_RESET;
            end
        end
        else if (do_write && w_lane_q)
        begin
            if (aw_addr_q[7:6] == DUTY_BLOCK_SEL)
            begin
                duty_value_reg_q[aw_addr_q[5:2]] <= w_byte_q;
            end
            else
            begin
                unique case (aw_addr_q)
                    PIN_ENABLE_LOW_OFF:  pin_enable_reg_low_q  <= w_byte_q;
                    PIN_ENABLE_HIGH_OFF: pin_enable_reg_high_q <= w_byte_q;
                    CLOCK_SELECT_OFF:    clock_select_reg_q    <= w_byte_q & CLOCK_SELECT_WMASK;
                    PWM_SELECT_OFF:      pwm_select_reg_q      <= w_byte_q[1:0];
                    POLARITY_LOW_OFF:    polarity_reg_low_q    <= w_byte_q;
                    POLARITY_HIGH_OFF:   polarity_reg_high_q   <= w_byte_q;
                    PORT1_DIR_OFF:       port1_direction_reg_q <= w_byte_q;
                    PORT2_DIR_OFF:       port2_direction_reg_q <= w_byte_q;
                    PORT1_DATA_OFF:      port1_data_reg_q      <= w_byte_q;
                    PORT2_DATA_OFF:      port2_data_reg_q      <= w_byte_q;
                    SYSTEM_CONTROL_OFF:  system_control_reg_q  <= w_byte_q[2:0];
                    default:             ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        read_value = '0;
        read_hit   = 1'b1;
        if (araddr[7:6] == DUTY_BLOCK_SEL)
        begin
            read_value[7:0] = duty_value_reg_q[araddr[5:2]];
        end
        else
        begin
            unique case (araddr)
                PIN_ENABLE_LOW_OFF:  read_value[7:0] = pin_enable_reg_low_q;
                PIN_ENABLE_HIGH_OFF: read_value[7:0] = pin_enable_reg_high_q;
                CLOCK_SELECT_OFF:    read_value[7:0] = clock_select_reg_q;
                PWM_SELECT_OFF:      read_value[1:0] = pwm_select_reg_q;
                POLARITY_LOW_OFF:    read_value[7:0] = polarity_reg_low_q;
                POLARITY_HIGH_OFF:   read_value[7:0] = polarity_reg_high_q;
                PORT1_DIR_OFF:       read_value[7:0] = port1_direction_reg_q;
                PORT2_DIR_OFF:       read_value[7:0] = port2_direction_reg_q;
                PORT1_DATA_OFF:      read_value[7:0] = port1_data_reg_q;
                PORT2_DATA_OFF:      read_value[7:0] = port2_data_reg_q;
                SYSTEM_CONTROL_OFF:  read_value[2:0] = system_control_reg_q;
                PIN_STATE_OFF:       read_value[15:0] = pin_sync_q;
                COUNTER_OFF:         read_value[7:0] = counter_q;
                default:             read_hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready   <= 1'b1;
            rvalid    <= 1'b0;
            rdata     <= '0;
            rresp     <= RESP_OKAY;
            ar_addr_q <= '0;
        end
        else if (arvalid && arready)
        begin
            arready   <= 1'b0;
            rvalid    <= 1'b1;
            rdata     <= read_value;
            rresp     <= read_hit ? RESP_OKAY : RESP_SLVERR;
            ar_addr_q <= araddr;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end
        else
        begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Counter clock and shared counter
    // ----------------------------------------------------------------
    // A tick enable stands in for a gated clock, keeping one clock domain
    always_comb
    begin
        tick = 1'b0;
        if (pwm_select_reg_q.counter_clock_enable)
        begin
            if (!pwm_select_reg_q.counter_clock_source)
            begin
                tick = 1'b1;
            end
            else
            begin
                unique case (clock_select_reg_q[CLK_SEL_LSB+1 -: 2])
                    2'h0: tick = prescale_q[0];
                    2'h1: tick = &prescale_q[1:0];
                    2'h2: tick = &prescale_q[2:0];
                    2'h3: tick = &prescale_q;
                endcase
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prescale_q <= '0;
            counter_q  <= '0;
        end
        else
        begin
            prescale_q <= prescale_q + 4'h1;
            if (tick)
            begin
                counter_q <= counter_q + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Waveform and pin mux
    // ----------------------------------------------------------------
    // Basic pulse high sits at the end of each 16-slot pulse, so the added
    // slot just before its rising edge stays inside the same pulse
    always_comb
    begin
        port_allowed = system_control_reg_q.single_chip_mode ||
                       (system_control_reg_q.io_select_enable &&
                        !system_control_reg_q.area_chip_select_enable);
        for (int i = 0; i < NUM_CHANNELS; i++)
        begin
            logic [3:0] upper;
            logic [3:0] lower;
            logic [3:0] slot;
            logic [3:0] pulse_rev;
            logic       basic;
            logic       extra;
            upper     = duty_value_reg_q[i][7:4];
            lower     = duty_value_reg_q[i][3:0];
            slot      = counter_q[3:0];
            pulse_rev = {counter_q[4], counter_q[5], counter_q[6], counter_q[7]};
            basic     = ({1'b0, slot} >= (5'h10 - {1'b0, upper}));
            extra     = (slot == (4'hf - upper)) && ({1'b0, pulse_rev} > (5'h0f - {1'b0, lower}));
            pwm_wave[i]  = (basic || extra) ^ polarity_bit[i];
            pin_out_d[i] = channel_output_enable[i] ? pwm_wave[i] :
                           (port_allowed ? port_data[i] : address_bus[i]);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= '0;
            pin_oe  <= '0;
        end
        else
        begin
            pin_out <= pin_out_d;
            pin_oe  <= pin_direction;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_div16_select;
        pwm_select_reg_q.counter_clock_enable && pwm_select_reg_q.counter_clock_source &&
        clock_select_reg_q[2:1] == 2'h3;
    endsequence

    sequence s_counter_wrap;
        tick && counter_q == 8'hff;
    endsequence

    a_input_pin_released: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_direction[0] |=> !pin_oe[0])
        else $error("pin driven while direction is input");

    a_pwm_pin_wave: assert property (@(posedge aclk) disable iff (!aresetn)
        pin_direction[9] && channel_output_enable[9] |=> pin_oe[9] && pin_out[9] == $past(pwm_wave[9]))
        else $error("PWM pin does not carry its waveform");

    a_port_data_out: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_enable_reg_low_q[2] && system_control_reg_q.single_chip_mode |=> pin_out[2] == $past(port1_data_reg_q[2]))
        else $error("port output pin does not carry port data");

    a_address_bus_out: assert property (@(posedge aclk) disable iff (!aresetn)
        !pin_enable_reg_high_q[0] && !system_control_reg_q.single_chip_mode &&
        system_control_reg_q.area_chip_select_enable |=> pin_out[8] == $past(address_bus[8]))
        else $error("address bus missing on a pin barred from port output");

    a_reserved_bit_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && ar_addr_q == CLOCK_SELECT_OFF |-> rdata[3] == 1'b0)
        else $error("clock select bit 3 reads nonzero");

    a_clock_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
        !pwm_select_reg_q.counter_clock_enable |=> counter_q == $past(counter_q))
        else $error("counter moved while clock disabled");

    a_div16_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        tick ##0 s_div16_select ##1 (s_div16_select [*8]) |-> !tick)
        else $error("divide by 16 ticks too soon");

    a_period_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        s_counter_wrap |=> counter_q == 8'h00)
        else $error("conversion period does not wrap at 256");

    a_pulse_zero_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        counter_q[7:4] == 4'h0 && duty_value_reg_q[9][7:4] == 4'h0 && !polarity_bit[9] |-> !pwm_wave[9])
        else $error("basic pulse 0 received an added pulse");

    a_added_slot: assert property (@(posedge aclk) disable iff (!aresetn)
        duty_value_reg_q[9] == 8'h01 && !polarity_bit[9] && counter_q == 8'hff |-> pwm_wave[9])
        else $error("added pulse missing at the last slot");

endmodule : pulse_addition_pwm_outputs

//--- shared/pwm_pkg.sv
/*
 * Constants and carrier types for the sixteen-channel pulse-addition PWM block.
 * Assumes a single 125 MHz clock and register access over a 32-bit AXI4-Lite slave.
 */
package pwm_pkg;

    localparam int unsigned NUM_CHANNELS = 16;
    localparam int unsigned ADDR_W       = 8;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] PIN_ENABLE_LOW_OFF  = 8'h00;
    localparam logic [7:0] PIN_ENABLE_HIGH_OFF = 8'h04;
    localparam logic [7:0] CLOCK_SELECT_OFF    = 8'h08;
    localparam logic [7:0] PWM_SELECT_OFF      = 8'h0c;
    localparam logic [7:0] POLARITY_LOW_OFF    = 8'h10;
    localparam logic [7:0] POLARITY_HIGH_OFF   = 8'h14;
    localparam logic [7:0] PORT1_DIR_OFF       = 8'h18;
    localparam logic [7:0] PORT2_DIR_OFF       = 8'h1c;
    localparam logic [7:0] PORT1_DATA_OFF      = 8'h20;
    localparam logic [7:0] PORT2_DATA_OFF      = 8'h24;
    localparam logic [7:0] SYSTEM_CONTROL_OFF  = 8'h28;
    localparam logic [7:0] PIN_STATE_OFF       = 8'h2c;
    localparam logic [7:0] COUNTER_OFF         = 8'h30;
    localparam logic [1:0] DUTY_BLOCK_SEL      = 2'h1;

    // ----------------------------------------------------------------
    // Field layouts and reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CLOCK_SELECT_WMASK  = 8'hf7;
    localparam logic [7:0] REG_RESET           = 8'h00;
    localparam int unsigned CLK_SEL_LSB        = 1;
    localparam logic [1:0] RESP_OKAY           = 2'h0;
    localparam logic [1:0] RESP_SLVERR         = 2'h2;

    typedef struct packed {
        logic counter_clock_enable;
        logic counter_clock_source;
    } pwm_select_type;

    typedef struct packed {
        logic area_chip_select_enable;
        logic io_select_enable;
        logic single_chip_mode;
    } system_control_type;

endpackage : pwm_pkg

//--- verification/pwm_load_model.sv
/*
 * Load model on the sixteen PWM pins: pull-ups and a high-cycle counter.
 * Assumes pin_out and pin_oe come from the PWM block on aclk.
 */
module pwm_load_model (
    input  wire logic        aclk,
    input  wire logic [15:0] pin_out,
    input  wire logic [15:0] pin_oe,
    input  wire logic [3:0]  sel,
    input  wire logic        clr,
    output logic      [15:0] pin_in,
    output logic      [15:0] high_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pull-up on released pins, so a pin never keeps its last driven level
    assign pin_in = (pin_out & pin_oe) | ~pin_oe;
    always_ff @(posedge aclk)
    begin
        if (clr)
            high_cnt <= 16'h0000;
        else if (pin_in[sel])
            high_cnt <= high_cnt + 16'h0001;
    end
endmodule : pwm_load_model

//--- verification/tb_pulse_addition_pwm_outputs.sv
/*
 * Self-checking bench: AXI4-Lite register tasks, port pin and PWM duty checks.
 * Assumes the pwm_pkg offsets and the load model with pull-ups on every pin.
 */
module tb_pulse_addition_pwm_outputs import pwm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, d;
    logic [31:0] wdata = 32'h0, rdata, rd_q, tmp;
    logic [1:0]  bresp, rresp, rr_q, br_q;
    logic [15:0] pin_in, pin_out, pin_oe, high_cnt, address_bus = 16'hffff;
    int bad_count = 0, n_checks = 0, cyc = 0;
    pulse_addition_pwm_outputs dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pin_in(pin_in), .address_bus(address_bus), .pin_out(pin_out),
        .pin_oe(pin_oe));
    pwm_load_model load_u (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe), .sel(4'h9),
        .clr(clr), .pin_in(pin_in), .high_cnt(high_cnt));
    always #4 aclk = ~aclk;
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            final_report();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        awaddr  <= a;
        wdata   <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        br_q = bresp;
        bready <= 1'b0;
        // One edge between calls, so bready is never assigned twice in a step
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rd_q = rdata;
        rr_q = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    // Window must be a whole number of conversion periods, whatever its phase
    task automatic meas(input int w, input logic [15:0] e);
        clr <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        repeat (w) @(posedge aclk);
        #1;
        chk("high count", {16'h0000, e}, {16'h0000, high_cnt});
        @(posedge aclk);
    endtask : meas
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] offs [3] = '{PIN_ENABLE_LOW_OFF, PIN_ENABLE_HIGH_OFF, CLOCK_SELECT_OFF};
        logic [7:0] sysv [4] = '{8'h01, 8'h02, 8'h06, 8'h00};
        logic [7:0] duty [6] = '{8'h00, 8'h01, 8'h0f, 8'h83, 8'hf0, 8'hff};
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            rd(offs[i]);
            chk("reset value", 32'h0, rd_q);
        end
        rd(8'hfc);
        chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rr_q});
        wr(8'hfc, 8'h55);
        chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, br_q});
        wr(CLOCK_SELECT_OFF, 8'h0e);
        chk("write resp", {30'h0, RESP_OKAY}, {30'h0, br_q});
        rd(CLOCK_SELECT_OFF);
        chk("read resp", {30'h0, RESP_OKAY}, {30'h0, rr_q});
        chk("clock select", 32'h00000006, rd_q);
        $display("test registers done");
        wr(SYSTEM_CONTROL_OFF, 8'h01);
        wr(PORT1_DATA_OFF, 8'h00);
        wr(PORT1_DIR_OFF, 8'h01);
        repeat (4) @(posedge aclk);
        chk("pin oe", 32'h00000001, {16'h0000, pin_oe});
        rd(PIN_STATE_OFF);
        chk("pin state", 32'h0000fffe, rd_q);
        for (int i = 0; i < 4; i++)
        begin
            wr(SYSTEM_CONTROL_OFF, sysv[i]);
            repeat (2) @(posedge aclk);
            chk("port pin mode", {31'h0, i > 1}, {31'h0, pin_out[0]});
        end
        wr(SYSTEM_CONTROL_OFF, 8'h01);
        wr(PORT1_DATA_OFF, 8'h05);
        repeat (2) @(posedge aclk);
        chk("port data pin", 32'h00000001, {31'h0, pin_out[0]});
        $display("test port pins done");
        wr(PORT2_DIR_OFF, 8'h02);
        wr(PIN_ENABLE_HIGH_OFF, 8'h02);
        wr(PWM_SELECT_OFF, 8'h02);
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h64, duty[i]);
            meas(256, {8'h00, duty[i]});
        end
        wr(8'h64, 8'h83);
        wr(POLARITY_HIGH_OFF, 8'h02);
        meas(256, 16'h007d);
        wr(POLARITY_HIGH_OFF, 8'h00);
        wr(PWM_SELECT_OFF, 8'h03);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'(i * 2);
            wr(CLOCK_SELECT_OFF, d);
            meas(256 << (i + 1), 16'(131 << (i + 1)));
        end
        wr(PWM_SELECT_OFF, 8'h00);
        rd(COUNTER_OFF);
        tmp = rd_q;
        repeat (20) @(posedge aclk);
        rd(COUNTER_OFF);
        chk("stopped counter", tmp, rd_q);
        $display("test pwm done");
        final_report();
    end
endmodule : tb_pulse_addition_pwm_outputs
